// file: include/ufc_pkg.sv
// Purpose: constants, field layout and types for the fifo trigger and flow control block
// Assumes: 8-bit register port, 128-word receive and transmit fifos
// Notes: threshold fields are 4 bits and count in steps of eight words
//
// Summary of operation
// - receive threshold flag raised when receive level reaches eight times its field
// - transmit threshold flag raised at or below eight times the transmit field
// - transmit count register returns words held in the transmit fifo
// - receive count register returns words held in the receive fifo
// - flow control bits 7-4 pick resume and halt characters
// - with transmitter flow control on, received resume/halt characters are dropped
// - software flow off plus special mode gives detection only, no transmit gating
// - both enabled: first pair does flow control, second pair special detection
// - bit 3 enables automatic software flow control with the selected characters
// - pin address mode: special char low nibble from pins, high from stop char
// - pin address mode ignores the stored low nibble of second stop char when matching
// - bit 1 gates the transmitter with the clear-to-send input
// - any clear-to-send change sets the change flag
// - bit 0 drives request-to-send from receive level at halt and resume levels
// - bits 7-6 pick which characters the transmitter sends: 10, 01, 11, 00
// - bits 5-4 pick which received characters are compared: 10, 01, 11, 00
// - all selection bits clear: no flow control and no detection
// - halt threshold equals eight times its field, 0 to 120
// - double character: first register is low byte, second the high byte
`default_nettype none
package ufc_pkg;
  localparam int CHAR_W = 8;
  localparam int NIB_W = 4;
  localparam int CNT_W = 8;
  localparam int FIFO_DEPTH = 128;

  localparam logic [7:0] ADDR_TRIG = 8'h10;
  localparam logic [7:0] ADDR_TX_CNT = 8'h11;
  localparam logic [7:0] ADDR_RX_CNT = 8'h12;
  localparam logic [7:0] ADDR_FLOW = 8'h13;
  localparam logic [7:0] TRIG_RESET = 8'hff;
  localparam logic [7:0] FLOW_RESET = 8'h00;

  // field positions in the trigger and flow registers
  localparam int TRIG_RX_LSB = 4;
  localparam int TRIG_TX_LSB = 0;
  localparam int FLOW_SEND_LSB = 6;
  localparam int FLOW_CMP_LSB = 4;
  localparam int FLOW_SW_EN = 3;
  localparam int FLOW_PIN_ADDR = 2;
  localparam int FLOW_AUTO_CTS = 1;
  localparam int FLOW_AUTO_RTS = 0;
  localparam int THR_RESUME_LSB = 4;
  localparam int THR_HALT_LSB = 0;

  // selection codes: bit 1 means first pair, bit 0 second pair
  localparam int SEL_P1 = 1;
  localparam int SEL_P2 = 0;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [2:0] LVL_PAD = 3'h0;

  typedef enum logic [1:0] {SEND_IDLE, SEND_LOW, SEND_HIGH} ufc_send_t;

  // eight times a 4-bit field
  function automatic logic [CNT_W-1:0] ufc_level(input logic [NIB_W-1:0] f);
    return {1'b0, f, LVL_PAD};
  endfunction : ufc_level

  function automatic logic ufc_hit(input logic [CHAR_W-1:0] c, input logic [CHAR_W-1:0] k,
                                   input logic en);
    return en && (c == k);
  endfunction : ufc_hit
endpackage : ufc_pkg
`default_nettype wire

// file: include/ufc_stream_if.sv
// Purpose: valid/ready word stream between the block's own modules
// Assumes: word taken on a clock edge where valid and ready are both high
// Notes: src drives data and valid, snk drives ready
`default_nettype none
interface ufc_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : ufc_stream_if
`default_nettype wire

// file: src/ufc_fifo.sv
// Purpose: synchronous flip-flop fifo with occupancy count
// Assumes: DEPTH is a power of two
// Notes: count is exact every cycle; simultaneous push and pop keep it steady
`default_nettype none
module ufc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic clk,
  input wire logic rst_n,
  ufc_stream_if.snk wr_s,
  ufc_stream_if.src rd_s,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  assign wr_s.ready = (count_q != CW'(DEPTH));
  assign rd_s.valid = (count_q != '0);
  assign rd_s.data = mem_q[rd_ptr_q];
  assign push = wr_s.valid && wr_s.ready;
  assign pop = rd_s.valid && rd_s.ready;
  assign count = count_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_s.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end
endmodule : ufc_fifo
`default_nettype wire

// file: src/ufc_top.sv
// Purpose: fifo trigger flags, fill counts and automatic flow control of a uart
// Assumes: one clock; cts_n and gpio_in are asynchronous pins
// Notes: character and mode registers live outside and arrive as plain inputs
`default_nettype none
module ufc_top #(
  parameter int DEPTH = ufc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // values held in neighbouring registers
  input wire logic [7:0] flow_threshold_register,
  input wire logic [7:0] first_resume_char,
  input wire logic [7:0] second_resume_char,
  input wire logic [7:0] first_stop_char,
  input wire logic [7:0] second_stop_char,
  input wire logic tx_disable,
  input wire logic special_detect_en,
  input wire logic [3:0] gpio_in,
  // modem pins
  input wire logic cts_n,
  output logic rts_n,
  // characters from the receiver
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  output logic rx_char_ready,
  // host reads receive fifo
  output logic host_rd_valid,
  output logic [7:0] host_rd_data,
  input wire logic host_rd_ready,
  // host writes transmit fifo
  input wire logic host_wr_valid,
  input wire logic [7:0] host_wr_data,
  output logic host_wr_ready,
  // characters to the transmitter
  output logic tx_char_valid,
  output logic [7:0] tx_char_data,
  input wire logic tx_char_ready,
  // status to the interrupt logic
  output logic receive_threshold_flag,
  output logic transmit_threshold_flag,
  output logic clear_to_send_change_flag,
  output logic special_char_flag,
  output logic transmit_empty_flag,
  output logic receive_empty_flag,
  output logic remote_halted
);
  localparam int CW = ufc_pkg::CNT_W;
  localparam int NW = ufc_pkg::NIB_W;
  localparam int CH = ufc_pkg::CHAR_W;

  ////////////////////////////////////////////////////////////////////////////
  // fifos
  ufc_stream_if #(.W(CH)) rx_in_s ();
  ufc_stream_if #(.W(CH)) rx_out_s ();
  ufc_stream_if #(.W(CH)) tx_in_s ();
  ufc_stream_if #(.W(CH)) tx_out_s ();
  logic [CW-1:0] rx_count;
  logic [CW-1:0] tx_count;

  ufc_fifo #(.WIDTH(CH), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wr_s(rx_in_s),
    .rd_s(rx_out_s),
    .count(rx_count)
  );

  ufc_fifo #(.WIDTH(CH), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wr_s(tx_in_s),
    .rd_s(tx_out_s),
    .count(tx_count)
  );

  assign host_rd_valid = rx_out_s.valid;
  assign host_rd_data = rx_out_s.data;
  assign rx_out_s.ready = host_rd_ready;
  assign tx_in_s.valid = host_wr_valid;
  assign tx_in_s.data = host_wr_data;
  assign host_wr_ready = tx_in_s.ready;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] trig_q;
  logic [7:0] flow_q;
  logic [7:0] rdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= ufc_pkg::TRIG_RESET;
      flow_q <= ufc_pkg::FLOW_RESET;
    end else if (reg_wr_en) begin
      if (reg_addr == ufc_pkg::ADDR_TRIG) begin
        trig_q <= reg_wdata;
      end
      if (reg_addr == ufc_pkg::ADDR_FLOW) begin
        flow_q <= reg_wdata;
      end
    end
  end

  // counts are live, so a read during traffic may be one word stale by the time it is used
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (reg_rd_en) begin
      case (reg_addr)
        ufc_pkg::ADDR_TRIG: rdata_q <= trig_q;
        ufc_pkg::ADDR_TX_CNT: rdata_q <= tx_count;
        ufc_pkg::ADDR_RX_CNT: rdata_q <= rx_count;
        ufc_pkg::ADDR_FLOW: rdata_q <= flow_q;
        default: rdata_q <= '0;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic cts_s1_q;
  logic cts_s2_q;
  logic cts_s3_q;
  logic [NW-1:0] gpio_s1_q;
  logic [NW-1:0] gpio_s2_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // clear-to-send level, so leaving reset gives no false change pulse
      cts_s1_q <= 1'b0;
      cts_s2_q <= 1'b0;
      cts_s3_q <= 1'b0;
      gpio_s1_q <= '0;
      gpio_s2_q <= '0;
    end else begin
      cts_s1_q <= cts_n;
      cts_s2_q <= cts_s1_q;
      cts_s3_q <= cts_s2_q;
      gpio_s1_q <= gpio_in;
      gpio_s2_q <= gpio_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  logic sw_en;
  logic [1:0] sel_send;
  logic [1:0] sel_cmp;
  logic fl1;
  logic fl2;
  logic sp1;
  logic sp2;
  logic [CH-1:0] stop2_eff;
  logic [CW-1:0] halt_lvl;
  logic [CW-1:0] resume_lvl;

  assign sw_en = flow_q[ufc_pkg::FLOW_SW_EN];
  assign sel_send = flow_q[ufc_pkg::FLOW_SEND_LSB +: 2];
  assign sel_cmp = flow_q[ufc_pkg::FLOW_CMP_LSB +: 2];
  // second pair goes to detection when both features are on
  assign fl1 = sw_en && sel_cmp[ufc_pkg::SEL_P1];
  assign fl2 = sw_en && sel_cmp[ufc_pkg::SEL_P2] && !special_detect_en;
  assign sp1 = special_detect_en && !sw_en && sel_cmp[ufc_pkg::SEL_P1];
  assign sp2 = special_detect_en && sel_cmp[ufc_pkg::SEL_P2];
  // stored low nibble is replaced by the pins for matching only; discard and the sender still use it
  assign stop2_eff = flow_q[ufc_pkg::FLOW_PIN_ADDR] ?
                     {second_stop_char[CH-1:NW], gpio_s2_q} : second_stop_char;
  assign halt_lvl = ufc_pkg::ufc_level(flow_threshold_register[ufc_pkg::THR_HALT_LSB +: NW]);
  assign resume_lvl = ufc_pkg::ufc_level(flow_threshold_register[ufc_pkg::THR_RESUME_LSB +: NW]);

  ////////////////////////////////////////////////////////////////////////////
  // receive path
  logic on_hit;
  logic off_hit;
  logic sp_hit;
  logic discard;
  logic rx_take;
  logic remote_halt_q;
  logic special_q;

  assign on_hit = ufc_pkg::ufc_hit(rx_char_data, first_resume_char, fl1) ||
                  ufc_pkg::ufc_hit(rx_char_data, second_resume_char, fl2);
  assign off_hit = ufc_pkg::ufc_hit(rx_char_data, first_stop_char, fl1) ||
                   ufc_pkg::ufc_hit(rx_char_data, stop2_eff, fl2);
  assign sp_hit = ufc_pkg::ufc_hit(rx_char_data, first_resume_char, sp1) ||
                  ufc_pkg::ufc_hit(rx_char_data, first_stop_char, sp1) ||
                  ufc_pkg::ufc_hit(rx_char_data, second_resume_char, sp2) ||
                  ufc_pkg::ufc_hit(rx_char_data, stop2_eff, sp2);
  // dropped characters follow the pairs our own sender uses, not the compare pairs
  assign discard = sw_en && (ufc_pkg::ufc_hit(rx_char_data, first_resume_char, sel_send[ufc_pkg::SEL_P1]) ||
                             ufc_pkg::ufc_hit(rx_char_data, first_stop_char, sel_send[ufc_pkg::SEL_P1]) ||
                             ufc_pkg::ufc_hit(rx_char_data, second_resume_char, sel_send[ufc_pkg::SEL_P2]) ||
                             ufc_pkg::ufc_hit(rx_char_data, second_stop_char, sel_send[ufc_pkg::SEL_P2]));
  // a dropped character is always taken, so it never waits on a full fifo
  assign rx_char_ready = discard || rx_in_s.ready;
  assign rx_in_s.valid = rx_char_valid && !discard;
  assign rx_in_s.data = rx_char_data;
  assign rx_take = rx_char_valid && rx_char_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_halt_q <= 1'b0;
    end else if (!sw_en) begin
      remote_halt_q <= 1'b0;
    end else if (rx_take && off_hit) begin
      remote_halt_q <= 1'b1;
    end else if (rx_take && on_hit) begin
      remote_halt_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      special_q <= 1'b0;
    end else begin
      special_q <= rx_take && sp_hit;
    end
  end
  assign special_char_flag = special_q;
  assign remote_halted = remote_halt_q;

  ////////////////////////////////////////////////////////////////////////////
  // flow character sender
  ufc_pkg::ufc_send_t send_q;
  logic send_off_q;
  logic local_stop_q;
  logic need_off;
  logic need_on;
  logic tx_gate;
  logic flow_ch_valid;
  logic [CH-1:0] flow_ch;

  assign need_off = sw_en && (sel_send != ufc_pkg::SEL_NONE) && !local_stop_q && (rx_count >= halt_lvl);
  assign need_on = sw_en && (sel_send != ufc_pkg::SEL_NONE) && local_stop_q && (rx_count <= resume_lvl);
  // transmitter halts between characters only, never mid-word
  assign tx_gate = !tx_disable && !(flow_q[ufc_pkg::FLOW_AUTO_CTS] && cts_s2_q);
  assign flow_ch_valid = (send_q != ufc_pkg::SEND_IDLE);

  always_comb begin
    flow_ch = '0;
    unique case (send_q)
      ufc_pkg::SEND_IDLE: flow_ch = '0;
      ufc_pkg::SEND_LOW: flow_ch = send_off_q ? first_stop_char : first_resume_char;
      ufc_pkg::SEND_HIGH: flow_ch = send_off_q ? second_stop_char : second_resume_char;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      send_q <= ufc_pkg::SEND_IDLE;
      send_off_q <= 1'b0;
      local_stop_q <= 1'b0;
    end else begin
      unique case (send_q)
        ufc_pkg::SEND_IDLE: begin
          if (!sw_en) begin
            local_stop_q <= 1'b0;
          end else if (need_off || need_on) begin
            send_off_q <= need_off;
            local_stop_q <= need_off;
            send_q <= sel_send[ufc_pkg::SEL_P1] ? ufc_pkg::SEND_LOW : ufc_pkg::SEND_HIGH;
          end
        end
        ufc_pkg::SEND_LOW: begin
          if (tx_gate && tx_char_ready) begin
            send_q <= sel_send[ufc_pkg::SEL_P2] ? ufc_pkg::SEND_HIGH : ufc_pkg::SEND_IDLE;
          end
        end
        ufc_pkg::SEND_HIGH: begin
          if (tx_gate && tx_char_ready) begin
            send_q <= ufc_pkg::SEND_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path: flow characters win over fifo data
  logic data_gate;
  assign data_gate = tx_gate && !remote_halt_q && !flow_ch_valid;
  assign tx_char_valid = flow_ch_valid ? tx_gate : (data_gate && tx_out_s.valid);
  assign tx_char_data = flow_ch_valid ? flow_ch : tx_out_s.data;
  assign tx_out_s.ready = data_gate && tx_char_ready;

  ////////////////////////////////////////////////////////////////////////////
  // request-to-send with hysteresis between halt and resume levels
  logic rts_n_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n_q <= 1'b0;
    end else if (!flow_q[ufc_pkg::FLOW_AUTO_RTS]) begin
      rts_n_q <= 1'b0;
    end else if (rx_count >= halt_lvl) begin
      rts_n_q <= 1'b1;
    end else if (rx_count <= resume_lvl) begin
      rts_n_q <= 1'b0;
    end
  end
  assign rts_n = rts_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  logic rx_thr_q;
  logic tx_thr_q;
  logic cts_chg_q;
  logic tx_empty_q;
  logic rx_empty_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_thr_q <= 1'b0;
      tx_thr_q <= 1'b0;
      tx_empty_q <= 1'b1;
      rx_empty_q <= 1'b1;
    end else begin
      rx_thr_q <= rx_count >= ufc_pkg::ufc_level(trig_q[ufc_pkg::TRIG_RX_LSB +: NW]);
      tx_thr_q <= tx_count <= ufc_pkg::ufc_level(trig_q[ufc_pkg::TRIG_TX_LSB +: NW]);
      tx_empty_q <= (tx_count == '0);
      rx_empty_q <= (rx_count == '0);
    end
  end

  // one-cycle pulse per edge seen on the synchronised pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cts_chg_q <= 1'b0;
    end else begin
      cts_chg_q <= cts_s2_q ^ cts_s3_q;
    end
  end

  assign receive_threshold_flag = rx_thr_q;
  assign transmit_threshold_flag = tx_thr_q;
  assign clear_to_send_change_flag = cts_chg_q;
  assign transmit_empty_flag = tx_empty_q;
  assign receive_empty_flag = rx_empty_q;
endmodule : ufc_top
`default_nettype wire

// file: verif/ufc_top_chk.sv
// Purpose: port-level checks of the fifo trigger and flow control block
// Assumes: trigger and flow registers shadowed here from the register port
// Notes: transmit flag check holds only while 8*15 exceeds the fifo depth
`default_nettype none
module ufc_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_disable,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic tx_char_valid,
  input wire logic receive_threshold_flag,
  input wire logic transmit_threshold_flag,
  input wire logic clear_to_send_change_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] trig_q;
  logic [7:0] flow_q;
  logic [2:0] stop_q;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 8'hff;
      flow_q <= 8'h00;
    end else if (reg_wr_en && reg_addr == 8'h10) begin
      trig_q <= reg_wdata;
    end else if (reg_wr_en && reg_addr == 8'h13) begin
      flow_q <= reg_wdata;
    end
  end
  // cycles of cts held high with the gate on; saturates so it never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) stop_q <= 3'h0;
    else if (!(cts_n && flow_q[1])) stop_q <= 3'h0;
    else if (stop_q != 3'h7) stop_q <= stop_q + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence cts_edge_s;
    $changed(cts_n);
  endsequence
  sequence chg_pulse_s;
    clear_to_send_change_flag ##1 !clear_to_send_change_flag;
  endsequence
  cts_flag_a: assert property (cts_edge_s |-> ##[2:4] chg_pulse_s)
    else $error("cts edge without one-cycle change flag");
  rd_trig_a: assert property (reg_rd_en && reg_addr == 8'h10 |=> reg_rdata == $past(trig_q))
    else $error("trigger register read wrong");
  rd_flow_a: assert property (reg_rd_en && reg_addr == 8'h13 |=> reg_rdata == $past(flow_q))
    else $error("flow register read wrong");
  rd_unmapped_a: assert property (reg_rd_en && (reg_addr < 8'h10 || reg_addr > 8'h13) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rts_off_a: assert property (!flow_q[0] && !$past(flow_q[0]) |-> !rts_n)
    else $error("rts driven while auto rts off");
  cts_gate_a: assert property (stop_q >= 3'h4 |-> !tx_char_valid)
    else $error("transmit while cts gate closed");
  dis_gate_a: assert property (tx_disable && $past(tx_disable) |-> !tx_char_valid)
    else $error("transmit while disabled");
  rx_zero_a: assert property (trig_q[7:4] == 4'h0 |-> ##1 receive_threshold_flag)
    else $error("receive flag low at zero level");
  tx_top_a: assert property (trig_q[3:0] == 4'hf |-> ##1 transmit_threshold_flag)
    else $error("transmit flag low under top level");
  cts_spur_a: assert property (clear_to_send_change_flag |-> $past(cts_n, 3) != $past(cts_n, 4))
    else $error("cts change flag without a pin edge");
endmodule : ufc_top_chk
bind ufc_top ufc_top_chk chk_u (.*);
`default_nettype wire

// file: verif/ufc_remote.sv
// Purpose: remote serial station at the character streams
// Assumes: put is called just after a rising edge
// Notes: released data line shows the inverse of the last byte
`default_nettype none
module ufc_remote (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char_data,
  output logic tx_char_ready,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  input wire logic rx_char_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int got;
  logic [7:0] last;
  assign tx_char_ready = !stall;
  initial begin
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      got <= 0;
      last <= 8'h00;
    end else if (tx_char_valid && tx_char_ready) begin
      got <= got + 1;
      last <= tx_char_data;
    end
  end
  task automatic put(input logic [7:0] c);
    rx_char_valid <= 1'b1;
    rx_char_data <= c;
    @(posedge clk);
    while (!rx_char_ready) @(posedge clk);
    rx_char_valid <= 1'b0;
    rx_char_data <= ~c;
    @(posedge clk);
  endtask : put
endmodule : ufc_remote
`default_nettype wire

// file: verif/ufc_top_bench.sv
// Purpose: self-checking bench of the fifo trigger and flow control block
// Assumes: fifo depth cut to 16 words
// Notes: remote station model on the character streams
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
`define WT(s, v) for (int i = 0; i < 80 && (s) !== (v); i++) @(posedge clk);
module ufc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, reg_wr_en, reg_rd_en, tx_disable, special_detect_en, cts_n, rts_n, stall;
  logic rx_char_valid, rx_char_ready, host_rd_valid, host_rd_ready, host_wr_valid, host_wr_ready;
  logic tx_char_valid, tx_char_ready, receive_threshold_flag, transmit_threshold_flag, seen;
  logic clear_to_send_change_flag, special_char_flag, transmit_empty_flag, receive_empty_flag, remote_halted;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, flow_threshold_register, first_resume_char, second_resume_char;
  logic [7:0] first_stop_char, second_stop_char, rx_char_data, host_rd_data, host_wr_data, tx_char_data;
  logic [3:0] gpio_in;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  ufc_top #(.DEPTH(16)) dut_u (.*);
  ufc_remote rem_u (.*);
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (special_char_flag === 1'b1) seen <= 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    @(posedge clk);
    `CHK("rdata", e, reg_rdata)
  endtask : rc
  task automatic hw(input logic [7:0] d);
    host_wr_valid <= 1'b1;
    host_wr_data <= d;
    @(posedge clk);
    while (!host_wr_ready) @(posedge clk);
    host_wr_valid <= 1'b0;
    @(posedge clk);
  endtask : hw
  task automatic drain;
    host_rd_ready <= 1'b1;
    `WT(receive_empty_flag, 1'b1)
    host_rd_ready <= 1'b0;
    @(posedge clk);
  endtask : drain
  task automatic sp(input logic [7:0] c, input logic e);
    seen = 1'b0;
    rem_u.put(c);
    repeat (3) @(posedge clk);
    `CHK("special", e, seen)
  endtask : sp
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rc(8'h10, 8'hff);
    rc(8'h11, 8'h00);
    rc(8'h12, 8'h00);
    rc(8'h13, 8'h00);
    wr(8'h12, 8'h55);
    rc(8'h12, 8'h00);
    rc(8'h20, 8'h00);
    wr(8'h10, 8'h0f);
    rc(8'h10, 8'h0f);
    `CHK("rxthr", 1'b1, receive_threshold_flag)
    wr(8'h13, 8'ha5);
    rc(8'h13, 8'ha5);
    wr(8'h13, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_buf;
    int n;
    tx_disable <= 1'b1;
    @(posedge clk);
    n = 0;
    host_wr_valid <= 1'b1;
    repeat (20) begin
      host_wr_data <= n[7:0];
      @(posedge clk);
      if (host_wr_ready) n++;
    end
    host_wr_valid <= 1'b0;
    `CHK("accepted", 16, n)
    rc(8'h11, 8'h10);
    stall <= 1'b1;
    tx_disable <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("stalled", 0, rem_u.got)
    stall <= 1'b0;
    `WT(transmit_empty_flag, 1'b1)
    `CHK("sent", 16, rem_u.got)
    `CHK("last", 8'h0f, rem_u.last)
    rc(8'h11, 8'h00);
    $display("test buffer done");
  endtask : t_buf
  task automatic t_trig;
    wr(8'h10, 8'h10);
    `CHK("txthr", 1'b1, transmit_threshold_flag)
    repeat (7) rem_u.put(8'h41);
    @(posedge clk);
    `CHK("rxthr", 1'b0, receive_threshold_flag)
    rc(8'h12, 8'h07);
    rem_u.put(8'h42);
    @(posedge clk);
    `CHK("rxthr", 1'b1, receive_threshold_flag)
    tx_disable <= 1'b1;
    hw(8'h30);
    @(posedge clk);
    `CHK("txthr", 1'b0, transmit_threshold_flag)
    tx_disable <= 1'b0;
    `WT(transmit_empty_flag, 1'b1)
    drain();
    wr(8'h10, 8'hff);
    $display("test trigger done");
  endtask : t_trig
  task automatic t_disc;
    first_resume_char <= 8'h17;
    first_stop_char <= 8'h19;
    wr(8'h13, 8'ha8);
    rem_u.put(8'h19);
    `CHK("halted", 1'b1, remote_halted)
    rem_u.put(8'h17);
    `CHK("halted", 1'b0, remote_halted)
    rem_u.put(8'h41);
    rc(8'h12, 8'h01);
    `CHK("rdvalid", 1'b1, host_rd_valid)
    `CHK("rxdata", 8'h41, host_rd_data)
    wr(8'h13, 8'h08);
    rem_u.put(8'h17);
    rc(8'h12, 8'h02);
    drain();
    wr(8'h13, 8'h00);
    $display("test discard done");
  endtask : t_disc
  task automatic t_spec;
    special_detect_en <= 1'b1;
    gpio_in <= 4'h5;
    wr(8'h13, 8'h10);
    sp(8'h12, 1'b1);
    sp(8'h11, 1'b0);
    wr(8'h13, 8'h14);
    sp(8'ha5, 1'b1);
    sp(8'ha3, 1'b0);
    wr(8'h13, 8'h00);
    sp(8'h12, 1'b0);
    special_detect_en <= 1'b0;
    drain();
    $display("test special done");
  endtask : t_spec
  task automatic t_rts;
    flow_threshold_register <= 8'h12;
    wr(8'h13, 8'h89);
    repeat (8) rem_u.put(8'h41);
    @(posedge clk);
    `CHK("rts", 1'b0, rts_n)
    repeat (8) rem_u.put(8'h41);
    `WT(rts_n, 1'b1)
    `CHK("rts", 1'b1, rts_n)
    @(posedge clk);
    `CHK("flowch", 8'h19, rem_u.last)
    drain();
    `WT(rts_n, 1'b0)
    `CHK("rts", 1'b0, rts_n)
    `CHK("flowch", 8'h17, rem_u.last)
    wr(8'h13, 8'h00);
    $display("test rts done");
  endtask : t_rts
  task automatic t_cts;
    int n;
    tx_disable <= 1'b1;
    wr(8'h13, 8'h02);
    cts_n <= 1'b1;
    `WT(clear_to_send_change_flag, 1'b1)
    `CHK("ctsflag", 1'b1, clear_to_send_change_flag)
    hw(8'h33);
    n = rem_u.got;
    tx_disable <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("held", n, rem_u.got)
    cts_n <= 1'b0;
    `WT(transmit_empty_flag, 1'b1)
    `CHK("released", n + 1, rem_u.got)
    wr(8'h13, 8'h00);
    $display("test cts done");
  endtask : t_cts
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {reg_wr_en, reg_rd_en, tx_disable, special_detect_en, cts_n, stall} = 6'h00;
    {host_rd_ready, host_wr_valid, seen} = 3'h0;
    {reg_addr, reg_wdata, host_wr_data} = 24'h000000;
    flow_threshold_register = 8'h01;
    first_resume_char = 8'h11;
    second_resume_char = 8'h12;
    first_stop_char = 8'h13;
    second_stop_char = 8'ha3;
    gpio_in = 4'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_buf();
    t_trig();
    t_disc();
    t_spec();
    t_rts();
    t_cts();
    finish_test();
  end
endmodule : ufc_top_bench
`default_nettype wire
